// ===== design/mfc_pkg.sv
// shared constants and types of the frame-format classifier
package mfc_pkg;
	// header layout, byte offsets from the first byte of DA
	localparam logic [7:0] DA_BYTES = 8'h06;
	localparam logic [7:0] ADDR_LAST = 8'h0B;
	localparam logic [7:0] SECTAG_OFF_STD = 8'h0C;
	localparam logic [7:0] MPLS_HDR_END = 8'h0E;
	localparam logic [7:0] TAG_BYTES = 8'h04;
	localparam logic [7:0] LBL_BYTES = 8'h04;
	localparam logic [7:0] CNT_MAX = 8'hFF;
	// last sub-byte index inside each header element
	localparam logic [2:0] HALF_LAST = 3'h1;
	localparam logic [2:0] LBL_LAST = 3'h3;
	localparam logic [2:0] SEC_LAST = 3'h5;
	// tag counts allowed ahead of the SecTAG
	localparam logic [1:0] TAGS_NONE = 2'h0;
	localparam logic [1:0] TAGS_ONE = 2'h1;
	localparam logic [1:0] TAGS_TWO = 2'h2;
	// ethertypes
	localparam logic [15:0] ET_CTAG = 16'h8100;
	localparam logic [15:0] ET_STAG = 16'h88A8;
	localparam logic [15:0] ET_QINQ = 16'h9100;
	localparam logic [15:0] ET_MPLS = 16'h8847;
	localparam logic [15:0] ET_SECTAG = 16'h88E5;
	// field select bit positions
	localparam int F_DA = 0;
	localparam int F_SA = 1;
	localparam int F_TPID1 = 2;
	localparam int F_VID1 = 3;
	localparam int F_TPID2 = 4;
	localparam int F_VID2 = 5;
	localparam int F_ETYPE = 6;
	localparam int F_LBL1 = 7;
	localparam int F_LBL2 = 8;
	localparam int F_SECTAG = 9;
	localparam int FSEL_W = 10;
	localparam int SA_CFG_W = FSEL_W + 1;

	typedef enum logic {DIR_TX = 1'b0, DIR_RX = 1'b1} mfc_dir_t;
	typedef enum logic [1:0] {
		BYP_STD = 2'b00,
		BYP_TAG1 = 2'b01,
		BYP_TAG2 = 2'b10,
		BYP_MPLS = 2'b11
	} mfc_byp_t;
	typedef enum logic [2:0] {
		FMT_UNTAG = 3'b000,
		FMT_TAG1 = 3'b001,
		FMT_TAG2 = 3'b010,
		FMT_MPLS1 = 3'b011,
		FMT_MPLS2 = 3'b100
	} mfc_fmt_t;
	typedef struct packed {
		logic [7:0] data;
		logic sop;
		logic eop;
	} mfc_beat_t;
	typedef struct packed {
		logic key256;
		logic [FSEL_W-1:0] fsel;
	} mfc_sa_cfg_t;
	typedef struct packed {
		logic [47:0] da;
		logic [47:0] sa;
		logic [15:0] tpid1;
		logic [11:0] vid1;
		logic [15:0] tpid2;
		logic [11:0] vid2;
		logic [15:0] etype;
		logic [31:0] lbl1;
		logic [31:0] lbl2;
		logic [63:0] sectag;
	} mfc_key_t;
	typedef struct packed {
		mfc_key_t key;
		logic [FSEL_W-1:0] fields;
		mfc_fmt_t fmt;
		logic key256;
		logic [7:0] sectag_off;
		logic fmt_err;
	} mfc_res_t;
endpackage

// ===== design/mfc_skid2.sv
// two-entry buffer with valid/ready on both sides
`timescale 1ns/10ps
module mfc_skid2 #(
	parameter int W = 10
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// fill side
	input wire logic [W-1:0] wr_data,
	input wire logic wr_valid,
	output logic wr_ready,
	// drain side
	output logic [W-1:0] rd_data,
	output logic rd_valid,
	input wire logic rd_ready
);
	logic [W-1:0] ent_reg [2];
	logic [W-1:0] ent_next [2];
	logic wp_reg, wp_next, rp_reg, rp_next;
	logic [1:0] cnt_reg, cnt_next;
	logic push, pop;

	assign wr_ready = (cnt_reg != 2'h2);
	assign rd_valid = (cnt_reg != 2'h0);
	assign rd_data = ent_reg[rp_reg];
	assign push = wr_valid & wr_ready;
	assign pop = rd_valid & rd_ready;

	always_comb begin
		ent_next = ent_reg;
		wp_next = wp_reg ^ push;
		rp_next = rp_reg ^ pop;
		cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
		if (push) begin
			ent_next[wp_reg] = wr_data;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ent_reg[0] <= '0;
			ent_reg[1] <= '0;
			wp_reg <= 1'b0;
			rp_reg <= 1'b0;
			cnt_reg <= 2'h0;
		end else begin
			ent_reg <= ent_next;
			wp_reg <= wp_next;
			rp_reg <= rp_next;
			cnt_reg <= cnt_next;
		end
	end
endmodule

// ===== design/mfc_sa_ram.sv
// per-SA configuration memory, registered read
`timescale 1ns/10ps
module mfc_sa_ram #(
	parameter int W = 11,
	parameter int DEPTH = 64
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// write port
	input wire logic we,
	input wire logic [$clog2(DEPTH)-1:0] waddr,
	input wire logic [W-1:0] wdata,
	// read port
	input wire logic [$clog2(DEPTH)-1:0] raddr,
	output logic [W-1:0] rdata
);
	logic [W-1:0] mem [DEPTH];

	always_ff @(posedge clock) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rdata <= '0;
		end else begin
			rdata <= mem[raddr];
		end
	end
endmodule

// ===== design/mfc_classifier.sv
// frame-format detection and per-SA classification key extraction
`timescale 1ns/10ps
module mfc_classifier #(
	parameter int SA_NUM = 64
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// mode, sampled at start of frame
	input wire mfc_pkg::mfc_dir_t cfg_dir,
	input wire mfc_pkg::mfc_byp_t cfg_byp,
	// per-SA table write
	input wire logic sa_wr,
	input wire logic [$clog2(SA_NUM)-1:0] sa_wr_idx,
	input wire mfc_pkg::mfc_sa_cfg_t sa_wr_cfg,
	// frame in
	input wire logic [$clog2(SA_NUM)-1:0] in_sa_idx,
	input wire mfc_pkg::mfc_beat_t in_beat,
	input wire logic in_valid,
	output logic in_ready,
	// frame out
	output mfc_pkg::mfc_beat_t out_beat,
	output logic out_valid,
	input wire logic out_ready,
	// classification result
	output mfc_pkg::mfc_res_t res,
	output logic res_valid
);
	import mfc_pkg::*;

	typedef enum logic [2:0] {
		ST_ADDR = 3'b000,
		ST_TYPE = 3'b001,
		ST_TAG = 3'b010,
		ST_LBL = 3'b011,
		ST_SEC = 3'b100,
		ST_DONE = 3'b101
	} mfc_st_t;

	localparam int IW = $clog2(SA_NUM);

	mfc_st_t st_reg, st_next;
	logic [2:0] sub_reg, sub_next;
	logic [7:0] cnt_reg, cnt_next;
	logic [1:0] ntag_reg, ntag_next;
	logic [1:0] nlbl_reg, nlbl_next;
	logic sec_reg, sec_next;
	logic [23:0] sh_reg, sh_next;
	mfc_key_t key_reg, key_next;
	mfc_dir_t dir_reg, dir_next;
	mfc_byp_t byp_reg, byp_next;
	logic [IW-1:0] sa_idx_reg, sa_idx_next;
	mfc_res_t res_reg, res_next;
	logic res_valid_reg, res_valid_next;

	logic beat;
	mfc_sa_cfg_t sa_cfg;
	logic [FSEL_W-1:0] avail;
	logic [FSEL_W-1:0] fields;
	logic [7:0] sec_off;
	mfc_fmt_t fmt;
	mfc_key_t key_masked;

	assign beat = in_valid & in_ready;
	assign res = res_reg;
	assign res_valid = res_valid_reg;

	// a stalled receiver backs up into the buffer and from there into in_ready
	mfc_skid2 #(
		.W($bits(mfc_beat_t))
	) u_buf (
		.clock(clock),
		.rst(rst),
		.wr_data(in_beat),
		.wr_valid(in_valid),
		.wr_ready(in_ready),
		.rd_data(out_beat),
		.rd_valid(out_valid),
		.rd_ready(out_ready)
	);

	mfc_sa_ram #(
		.W(SA_CFG_W),
		.DEPTH(SA_NUM)
	) u_sa (
		.clock(clock),
		.rst(rst),
		.we(sa_wr),
		.waddr(sa_wr_idx),
		.wdata(sa_wr_cfg),
		.raddr(sa_idx_reg),
		.rdata(sa_cfg)
	);

	function automatic logic is_vlan(input logic [15:0] t);
		return (t == ET_CTAG) || (t == ET_STAG) || (t == ET_QINQ);
	endfunction

	// how many tags may precede the SecTAG, or be parsed before the Etype
	function automatic logic [1:0] tag_limit(input mfc_dir_t d, input mfc_byp_t m);
		logic [1:0] lim;
		lim = TAGS_NONE;
		if (d == DIR_TX) begin
			lim = (m == BYP_MPLS) ? TAGS_NONE : TAGS_TWO;
		end else if (m == BYP_TAG1) begin
			lim = TAGS_ONE;
		end else if (m == BYP_TAG2) begin
			lim = TAGS_TWO;
		end
		return lim;
	endfunction

	// parser: one header byte per accepted beat
	always_comb begin
		mfc_st_t st_v;
		logic [7:0] cnt_v;
		logic [7:0] b;
		logic [15:0] t;
		logic fin;
		logic err;
		st_v = in_beat.sop ? ST_ADDR : st_reg;
		cnt_v = in_beat.sop ? 8'h00 : cnt_reg;
		b = in_beat.data;
		t = {sh_reg[7:0], b};
		fin = 1'b0;
		err = 1'b0;
		st_next = st_reg;
		sub_next = sub_reg;
		cnt_next = cnt_reg;
		ntag_next = ntag_reg;
		nlbl_next = nlbl_reg;
		sec_next = sec_reg;
		sh_next = sh_reg;
		key_next = key_reg;
		dir_next = dir_reg;
		byp_next = byp_reg;
		sa_idx_next = sa_idx_reg;
		res_next = res_reg;
		res_valid_next = 1'b0;
		if (beat) begin
			sh_next = {sh_reg[15:0], b};
			cnt_next = (cnt_v == CNT_MAX) ? cnt_v : cnt_v + 8'h01;
			if (in_beat.sop) begin
				key_next = '0;
				ntag_next = 2'h0;
				nlbl_next = 2'h0;
				sec_next = 1'b0;
				sub_next = 3'h0;
				dir_next = cfg_dir;
				byp_next = cfg_byp;
				sa_idx_next = in_sa_idx;
			end
			unique case (st_v)
				ST_ADDR: begin
					if (cnt_v < DA_BYTES) begin
						key_next.da = {key_next.da[39:0], b};
					end else begin
						key_next.sa = {key_next.sa[39:0], b};
					end
					if (cnt_v == ADDR_LAST) begin
						st_next = ST_TYPE;
						sub_next = 3'h0;
					end else begin
						st_next = ST_ADDR;
					end
				end
				ST_TYPE: begin
					if (sub_reg != HALF_LAST) begin
						sub_next = HALF_LAST;
					end else begin
						sub_next = 3'h0;
						if (is_vlan(t) && (ntag_reg < tag_limit(dir_next, byp_next))) begin
							if (ntag_reg == 2'h0) begin
								key_next.tpid1 = t;
							end else begin
								key_next.tpid2 = t;
							end
							st_next = ST_TAG;
						end else if ((t == ET_MPLS) && (nlbl_reg == 2'h0)
							&& ((dir_next == DIR_TX) || (byp_next == BYP_MPLS))) begin
							key_next.etype = t;
							st_next = ST_LBL;
						end else if ((t == ET_SECTAG) && (dir_next == DIR_RX)) begin
							key_next.sectag[63:48] = t;
							sec_next = 1'b1;
							st_next = ST_SEC;
						end else begin
							if (dir_next == DIR_TX) begin
								key_next.etype = t;
							end
							fin = 1'b1;
						end
					end
				end
				ST_TAG: begin
					if (sub_reg != HALF_LAST) begin
						sub_next = HALF_LAST;
					end else begin
						sub_next = 3'h0;
						if (ntag_reg == 2'h0) begin
							key_next.vid1 = t[11:0];
						end else begin
							key_next.vid2 = t[11:0];
						end
						ntag_next = ntag_reg + 2'h1;
						st_next = ST_TYPE;
					end
				end
				ST_LBL: begin
					if (sub_reg != LBL_LAST) begin
						sub_next = sub_reg + 3'h1;
					end else begin
						sub_next = 3'h0;
						if (nlbl_reg == 2'h0) begin
							key_next.lbl1 = {sh_reg, b};
						end else begin
							key_next.lbl2 = {sh_reg, b};
						end
						nlbl_next = nlbl_reg + 2'h1;
						// bottom of stack, or the deepest label we keep
						if (sh_reg[0] || (nlbl_reg == 2'h1)) begin
							if (dir_next == DIR_RX) begin
								st_next = ST_TYPE;
							end else begin
								fin = 1'b1;
							end
						end
					end
				end
				ST_SEC: begin
					key_next.sectag[47:0] = {key_next.sectag[39:0], b};
					if (sub_reg != SEC_LAST) begin
						sub_next = sub_reg + 3'h1;
					end else begin
						sub_next = 3'h0;
						fin = 1'b1;
					end
				end
				ST_DONE: begin
					st_next = ST_DONE;
				end
				default: begin
					st_next = ST_DONE;
				end
			endcase
			// a frame that ends inside its headers still reports, flagged
			if (in_beat.eop && (st_v != ST_DONE) && !fin) begin
				fin = 1'b1;
				err = 1'b1;
			end
			if (fin) begin
				st_next = ST_DONE;
				res_valid_next = 1'b1;
				res_next.key = key_masked;
				res_next.fields = fields;
				res_next.fmt = fmt;
				res_next.key256 = sa_cfg.key256;
				res_next.sectag_off = sec_off;
				res_next.fmt_err = err || ((dir_next == DIR_RX) && !sec_next);
			end
		end
	end

	// fields that the detected format can offer
	always_comb begin
		avail = '0;
		avail[F_DA] = 1'b1;
		avail[F_SA] = 1'b1;
		avail[F_TPID1] = (ntag_next != 2'h0);
		avail[F_VID1] = (ntag_next != 2'h0);
		avail[F_TPID2] = (ntag_next == TAGS_TWO);
		avail[F_VID2] = (ntag_next == TAGS_TWO);
		avail[F_LBL1] = (nlbl_next != 2'h0);
		avail[F_LBL2] = (nlbl_next == 2'h2);
		avail[F_ETYPE] = (dir_next == DIR_TX) || (nlbl_next != 2'h0);
		avail[F_SECTAG] = (dir_next == DIR_RX) && sec_next;
		fields = avail & sa_cfg.fsel;
	end

	// zero every field the SA did not select
	always_comb begin
		key_masked = key_next;
		key_masked.da = fields[F_DA] ? key_next.da : '0;
		key_masked.sa = fields[F_SA] ? key_next.sa : '0;
		key_masked.tpid1 = fields[F_TPID1] ? key_next.tpid1 : '0;
		key_masked.vid1 = fields[F_VID1] ? key_next.vid1 : '0;
		key_masked.tpid2 = fields[F_TPID2] ? key_next.tpid2 : '0;
		key_masked.vid2 = fields[F_VID2] ? key_next.vid2 : '0;
		key_masked.etype = fields[F_ETYPE] ? key_next.etype : '0;
		key_masked.lbl1 = fields[F_LBL1] ? key_next.lbl1 : '0;
		key_masked.lbl2 = fields[F_LBL2] ? key_next.lbl2 : '0;
		key_masked.sectag = fields[F_SECTAG] ? key_next.sectag : '0;
	end

	// format and SecTAG offset; everything ahead of the offset stays in clear
	always_comb begin
		if (nlbl_next == 2'h2) begin
			fmt = FMT_MPLS2;
		end else if (nlbl_next == 2'h1) begin
			fmt = FMT_MPLS1;
		end else if (ntag_next == TAGS_TWO) begin
			fmt = FMT_TAG2;
		end else if (ntag_next == TAGS_ONE) begin
			fmt = FMT_TAG1;
		end else begin
			fmt = FMT_UNTAG;
		end
		unique case (byp_next)
			BYP_STD: begin
				sec_off = SECTAG_OFF_STD;
			end
			BYP_TAG1: begin
				sec_off = (ntag_next != 2'h0) ? SECTAG_OFF_STD + TAG_BYTES
					: SECTAG_OFF_STD;
			end
			BYP_TAG2: begin
				sec_off = SECTAG_OFF_STD + TAG_BYTES * {6'h00, ntag_next};
			end
			BYP_MPLS: begin
				sec_off = (nlbl_next != 2'h0) ? MPLS_HDR_END + LBL_BYTES * {6'h00, nlbl_next}
					: SECTAG_OFF_STD;
			end
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st_reg <= ST_DONE;
			sub_reg <= 3'h0;
			cnt_reg <= 8'h00;
			ntag_reg <= 2'h0;
			nlbl_reg <= 2'h0;
			sec_reg <= 1'b0;
			sh_reg <= '0;
			key_reg <= '0;
			dir_reg <= DIR_TX;
			byp_reg <= BYP_STD;
			sa_idx_reg <= '0;
			res_reg <= '0;
			res_valid_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			sub_reg <= sub_next;
			cnt_reg <= cnt_next;
			ntag_reg <= ntag_next;
			nlbl_reg <= nlbl_next;
			sec_reg <= sec_next;
			sh_reg <= sh_next;
			key_reg <= key_next;
			dir_reg <= dir_next;
			byp_reg <= byp_next;
			sa_idx_reg <= sa_idx_next;
			res_reg <= res_next;
			res_valid_reg <= res_valid_next;
		end
	end
endmodule

// ===== verif/mfc_classifier_sva.sv
// port-level assertions of the frame-format classifier
`timescale 1ns/10ps
module mfc_classifier_sva
	import mfc_pkg::*;
#(
	parameter int SA_NUM = 64
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// mode and table
	input wire mfc_pkg::mfc_dir_t cfg_dir,
	input wire mfc_pkg::mfc_byp_t cfg_byp,
	input wire logic sa_wr,
	input wire logic [$clog2(SA_NUM)-1:0] sa_wr_idx,
	input wire mfc_pkg::mfc_sa_cfg_t sa_wr_cfg,
	// stream
	input wire logic [$clog2(SA_NUM)-1:0] in_sa_idx,
	input wire mfc_pkg::mfc_beat_t in_beat,
	input wire logic in_valid,
	input wire logic in_ready,
	input wire mfc_pkg::mfc_beat_t out_beat,
	input wire logic out_valid,
	input wire logic out_ready,
	// result
	input wire mfc_pkg::mfc_res_t res,
	input wire logic res_valid
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// bypass mode of the frame in flight, latched when its first byte is taken
	mfc_byp_t byp_seen_reg;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			byp_seen_reg <= BYP_STD;
		end else if (in_valid && in_ready && in_beat.sop) begin
			byp_seen_reg <= cfg_byp;
		end
	end
	property p_take_empty;
		in_valid && in_ready && !out_valid |=> out_valid && out_beat == $past(in_beat);
	endproperty
	a_take_empty: assert property (p_take_empty) else $error("word not presented after take");
	property p_stall_hold;
		out_valid && !out_ready |=> out_valid && $stable(out_beat);
	endproperty
	a_stall_hold: assert property (p_stall_hold) else $error("output word changed while stalled");
	property p_full_refuse;
		!in_ready |-> out_valid;
	endproperty
	a_full_refuse: assert property (p_full_refuse) else $error("refusing while buffer empty");
	property p_full_stays;
		in_valid && !in_ready && !out_ready |=> !in_ready;
	endproperty
	a_full_stays: assert property (p_full_stays) else $error("full buffer freed without drain");
	property p_res_pulse;
		res_valid |=> !res_valid;
	endproperty
	a_res_pulse: assert property (p_res_pulse) else $error("result strobe longer than one cycle");
	property p_res_hold;
		!res_valid |-> $stable(res);
	endproperty
	a_res_hold: assert property (p_res_hold) else $error("result changed without strobe");
	property p_std_off;
		res_valid && !res.fmt_err && res.fmt == FMT_UNTAG |-> res.sectag_off == SECTAG_OFF_STD;
	endproperty
	a_std_off: assert property (p_std_off) else $error("untagged offset wrong");
	property p_tag_off;
		res_valid && !res.fmt_err && res.fmt inside {FMT_TAG1, FMT_TAG2}
			|-> res.sectag_off inside {8'h0C, 8'h10, 8'h14}
			&& (res.fmt == FMT_TAG2 || res.sectag_off != 8'h14);
	endproperty
	a_tag_off: assert property (p_tag_off) else $error("tagged offset wrong");
	property p_mpls_off;
		res_valid && !res.fmt_err && res.fmt inside {FMT_MPLS1, FMT_MPLS2}
			|-> res.sectag_off == ((byp_seen_reg != BYP_MPLS) ? SECTAG_OFF_STD
			: (res.fmt == FMT_MPLS1) ? 8'h12 : 8'h16);
	endproperty
	a_mpls_off: assert property (p_mpls_off) else $error("label stack offset wrong");
	property p_unsel_zero;
		res_valid |-> (res.fields[F_DA] || res.key.da == '0)
			&& (res.fields[F_VID2] || res.key.vid2 == '0)
			&& (res.fields[F_SECTAG] || res.key.sectag == '0);
	endproperty
	a_unsel_zero: assert property (p_unsel_zero) else $error("unselected field not zero");
	property p_no_lbl;
		res_valid && res.fmt inside {FMT_UNTAG, FMT_TAG1, FMT_TAG2}
			|-> !res.fields[F_LBL1] && !res.fields[F_LBL2];
	endproperty
	a_no_lbl: assert property (p_no_lbl) else $error("label field on a non-label frame");
endmodule

bind mfc_classifier mfc_classifier_sva #(.SA_NUM(SA_NUM)) i_mfc_classifier_sva (
	.clock(clock), .rst(rst), .cfg_dir(cfg_dir), .cfg_byp(cfg_byp), .sa_wr(sa_wr),
	.sa_wr_idx(sa_wr_idx), .sa_wr_cfg(sa_wr_cfg), .in_sa_idx(in_sa_idx), .in_beat(in_beat),
	.in_valid(in_valid), .in_ready(in_ready), .out_beat(out_beat), .out_valid(out_valid),
	.out_ready(out_ready), .res(res), .res_valid(res_valid)
);

// ===== verif/mfc_mac_sink.sv
// line-side frame sink that collects the output stream and can stall
`timescale 1ns/10ps
module mfc_mac_sink
	import mfc_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// stream
	input wire mfc_pkg::mfc_beat_t out_beat,
	input wire logic out_valid,
	output logic out_ready,
	// slow mode
	input wire logic stall
);
	mfc_beat_t got[$];
	logic [1:0] phase;
	initial begin
		out_ready = 1'b0;
		phase = 2'h0;
		forever begin
			@(posedge clock);
			if (!rst && out_valid && out_ready)
				got.push_back(out_beat);
			#1;
			phase = phase + 2'h1;
			// slow mode takes one word in four cycles, enough to fill the buffer
			out_ready = !(stall && phase != 2'h0);
		end
	end
endmodule

// ===== verif/mfc_classifier_bench.sv
// self-checking bench of the frame-format classifier
`timescale 1ns/10ps
module mfc_classifier_bench;
	import mfc_pkg::*;
	localparam logic [47:0] MAC_D = 48'h0A0B_0C0D_0E0F;
	localparam logic [47:0] MAC_S = 48'h1112_1314_1516;
	localparam logic [63:0] STAG = 64'h88E5_2C00_0000_0001;
	logic clock, rst, sa_wr, in_valid, in_ready, out_valid, out_ready, res_valid, stall;
	mfc_dir_t cfg_dir;
	mfc_byp_t cfg_byp;
	logic [5:0] sa_wr_idx, in_sa_idx;
	mfc_sa_cfg_t sa_wr_cfg;
	mfc_beat_t in_beat, out_beat;
	mfc_res_t res;
	int err_total, checked, nres;
	logic [7:0] fq[$];
	mfc_classifier #(.SA_NUM(64)) i_mfc_classifier (.clock(clock), .rst(rst),
		.cfg_dir(cfg_dir), .cfg_byp(cfg_byp), .sa_wr(sa_wr), .sa_wr_idx(sa_wr_idx),
		.sa_wr_cfg(sa_wr_cfg), .in_sa_idx(in_sa_idx), .in_beat(in_beat), .in_valid(in_valid),
		.in_ready(in_ready), .out_beat(out_beat), .out_valid(out_valid), .out_ready(out_ready),
		.res(res), .res_valid(res_valid));
	mfc_mac_sink i_mfc_mac_sink (.clock(clock), .rst(rst), .out_beat(out_beat),
		.out_valid(out_valid), .out_ready(out_ready), .stall(stall));
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	always @(posedge clock) if (res_valid === 1'b1) nres++;
	task conclude;
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task chk(input logic [63:0] g, input logic [63:0] e);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task add(input logic [63:0] v, input int n);
		for (int i = n - 1; i >= 0; i--) fq.push_back(v[8*i +: 8]);
	endtask
	task wsa(input logic [5:0] i, input logic k, input logic [9:0] f);
		sa_wr_idx <= i;
		sa_wr_cfg <= {k, f};
		sa_wr <= 1'b1;
		@(posedge clock);
		#1;
		sa_wr <= 1'b0;
		// one idle edge so a following write never re-raises the strobe in the same step
		@(posedge clock);
		#1;
	endtask
	// streams the queued header plus two payload bytes, then checks stream and strobe count
	task send(input mfc_dir_t d, input mfc_byp_t b, input logic [5:0] s);
		int n0, base;
		logic ok;
		fq.push_back(8'h5A);
		fq.push_back(8'hA5);
		cfg_dir <= d;
		cfg_byp <= b;
		in_sa_idx <= s;
		n0 = nres;
		base = i_mfc_mac_sink.got.size();
		for (int i = 0; i < fq.size(); i++) begin
			in_beat <= '{data: fq[i], sop: i == 0, eop: i == fq.size() - 1};
			in_valid <= 1'b1;
			do begin
				#3;
				ok = in_ready;
				@(posedge clock);
				#1;
			end while (ok !== 1'b1);
		end
		in_valid <= 1'b0;
		for (int k = 0; k < 300 && (nres == n0 || i_mfc_mac_sink.got.size() < base + fq.size()); k++)
			@(posedge clock);
		#1;
		chk(64'(nres - n0), 64'h1);
		for (int i = 0; i < fq.size(); i++)
			chk(i_mfc_mac_sink.got[base + i], {fq[i], i == 0, i == fq.size() - 1});
		fq.delete();
	endtask
	task cres(input mfc_fmt_t f, input logic [7:0] off, input logic [9:0] fl);
		chk(res.fmt, f);
		chk(res.sectag_off, off);
		chk(res.fields, fl);
		chk(res.fmt_err, 1'b0);
	endtask
	task t_std_tx;
		wsa(6'h00, 1'b0, 10'h3FF);
		add(MAC_D, 6);
		add(MAC_S, 6);
		add(16'h0800, 2);
		send(DIR_TX, BYP_STD, 6'h00);
		cres(FMT_UNTAG, 8'h0C, 10'h043);
		chk({res.key.da, res.key.etype}, {MAC_D, 16'h0800});
		stall <= 1'b1;
		add(MAC_D, 6);
		add(MAC_S, 6);
		add(32'h88A8_0123, 4);
		add(32'h8100_0456, 4);
		add(16'h0800, 2);
		send(DIR_TX, BYP_STD, 6'h00);
		stall <= 1'b0;
		cres(FMT_TAG2, 8'h0C, 10'h07F);
		chk({res.key.tpid1, res.key.vid1, res.key.tpid2, res.key.vid2},
			{16'h88A8, 12'h123, 16'h8100, 12'h456});
		add(MAC_D, 6);
		add(MAC_S, 6);
		add(32'h88A8_0123, 4);
		add(32'h8100_0456, 4);
		add(16'h0800, 2);
		send(DIR_TX, BYP_TAG1, 6'h00);
		cres(FMT_TAG2, 8'h10, 10'h07F);
	endtask
	task t_rx_byp;
		for (int t = 0; t < 3; t++) begin
			add(MAC_D, 6);
			add(MAC_S, 6);
			if (t > 0) add(32'h8100_0ABC, 4);
			if (t > 1) add(32'h88A8_0DEF, 4);
			add(STAG, 8);
			add(32'h8100_0777, 4);
			send(DIR_RX, mfc_byp_t'(t), 6'h00);
			cres(mfc_fmt_t'(t), 8'h0C + 8'(4 * t), 10'h203 | (t > 0 ? 10'h00C : 10'h000)
				| (t > 1 ? 10'h030 : 10'h000));
			chk(res.key.sectag, STAG);
			chk({res.key.vid1, res.key.vid2}, {t > 0 ? 12'hABC : 12'h000,
				t > 1 ? 12'hDEF : 12'h000});
		end
	endtask
	task t_mpls;
		add(MAC_D, 6);
		add(MAC_S, 6);
		add(16'h8847, 2);
		add(32'h0001_2040, 4);
		add(32'h0003_4140, 4);
		add(MAC_S, 6);
		send(DIR_TX, BYP_MPLS, 6'h00);
		cres(FMT_MPLS2, 8'h16, 10'h1C3);
		chk({res.key.lbl1, res.key.lbl2}, {32'h0001_2040, 32'h0003_4140});
		chk(res.key.etype, 16'h8847);
		add(MAC_D, 6);
		add(MAC_S, 6);
		add(16'h8847, 2);
		add(32'h0005_6140, 4);
		add(STAG, 8);
		send(DIR_RX, BYP_MPLS, 6'h00);
		cres(FMT_MPLS1, 8'h12, 10'h2C3);
		chk({res.key.lbl1, res.key.sectag[15:0]}, {32'h0005_6140, 16'h0001});
	endtask
	task t_per_sa;
		wsa(6'h05, 1'b1, 10'h001);
		wsa(6'h09, 1'b0, 10'h042);
		for (int s = 0; s < 2; s++) begin
			add(MAC_D, 6);
			add(MAC_S, 6);
			add(16'h0800, 2);
			send(DIR_TX, BYP_STD, s ? 6'h09 : 6'h05);
			chk(res.fields, s ? 10'h042 : 10'h001);
			chk(res.key256, s ? 1'b0 : 1'b1);
			chk(res.key.sa, s ? MAC_S : 48'h0);
		end
		// frame that ends on the last address byte, before the Etype (the two payload bytes complete the SA)
		add(MAC_D, 6);
		add(MAC_S, 4);
		send(DIR_TX, BYP_STD, 6'h05);
		chk(res.fmt_err, 1'b1);
	endtask
	initial begin
		rst = 1'b1;
		cfg_dir = DIR_TX;
		cfg_byp = BYP_STD;
		sa_wr = 1'b0;
		sa_wr_idx = 6'h00;
		sa_wr_cfg = '0;
		in_sa_idx = 6'h00;
		in_beat = '0;
		in_valid = 1'b0;
		stall = 1'b0;
		err_total = 0;
		checked = 0;
		repeat (16) @(posedge clock);
		#1;
		chk({in_ready, out_valid, res_valid}, 3'b100);
		rst = 1'b0;
		t_std_tx();
		t_rx_byp();
		t_mpls();
		t_per_sa();
		conclude();
	end
	initial begin
		#100000;
		err_total++;
		conclude();
	end
endmodule
